//--- nand_col_pkg.sv
// Package: command codes, register map and timing for the NAND column-op host controller
package nand_col_pkg;
	localparam logic [7:0] CMD_RAND_READ     = 8'h05;
	localparam logic [7:0] CMD_RAND_READ_2PL = 8'h06;
	localparam logic [7:0] CMD_READ_CONFIRM  = 8'he0;
	localparam logic [7:0] CMD_RAND_INPUT    = 8'h85;
	localparam logic [7:0] CMD_STATUS_ENH    = 8'h78;

	localparam logic [11:0] REG_CTRL    = 12'h000;
	localparam logic [11:0] REG_COLUMN  = 12'h004;
	localparam logic [11:0] REG_ROW     = 12'h008;
	localparam logic [11:0] REG_DATA    = 12'h00c;
	localparam logic [11:0] REG_STATUS  = 12'h010;

	// Ctrl fields: [2:0] operation, [3] start (self clearing), [4] data byte is write
	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_START    = 3;
	localparam int CTRL_DATA_WR  = 4;

	localparam logic [2:0] OP_RAND_READ   = 3'h0;
	localparam logic [2:0] OP_RAND_READ2  = 3'h1;
	localparam logic [2:0] OP_RAND_INPUT  = 3'h2;
	localparam logic [2:0] OP_PROG_INPUT  = 3'h3;
	localparam logic [2:0] OP_STATUS_ENH  = 3'h4;
	localparam logic [2:0] OP_DATA        = 3'h5;

	localparam int STAT_BUSY   = 0;
	localparam int STAT_MODE   = 1;
	localparam int STAT_BADOP  = 2;

	localparam int CLK_MHZ          = 200;
	localparam int STROBE_NS        = 25;
	localparam int CMD_TO_READ_NS   = 60;
	localparam int ADDR_TO_LOAD_NS  = 70;
	localparam int STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int CMD_TO_READ_CYC  = (CMD_TO_READ_NS * CLK_MHZ + 999) / 1000;
	localparam int ADDR_TO_LOAD_CYC = (ADDR_TO_LOAD_NS * CLK_MHZ + 999) / 1000;

	localparam logic [1:0] MODE_NONE   = 2'h0;
	localparam logic [1:0] MODE_OUTPUT = 2'h1;
	localparam logic [1:0] MODE_INPUT  = 2'h2;
	localparam logic [1:0] MODE_STATUS = 2'h3;

	typedef struct packed {
		logic [7:0] dq;
		logic       dqOe;
		logic       cle;
		logic       ale;
		logic       writeStrobeN;
		logic       readStrobeN;
	} nand_pins_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;
endpackage

//--- nand_column_host.sv
// Host controller issuing NAND column-address command sequences, configured over APB
// Summary of operation
// [R1] Random read: command 05h, two column bytes, then E0h; device enters output mode.
// [R2] Device takes random read when fully ready or during cache read.
// [R3] After E0h, host waits the command-to-read gap before first read strobe.
// [R4] Device stays in output mode until another valid command.
// [R5] Multi-die: host sends enhanced status 78h before a 05h-E0h read.
// [R6] Two-plane read: 06h, two column, three row bytes, then E0h.
// [R7] Device takes two-plane read only when fully ready.
// [R8] Host reissues 06h-E0h to switch plane after finishing current output.
// [R9] Device deselects dies not addressed by 06h-E0h after interleaved read.
// [R10] While dies busy, host selects die with 78h before 06h-E0h.
// [R11] Random input: 85h plus two column bytes; device enters input mode.
// [R12] Device takes 85h when fully ready or during cache program.
// [R13] Host waits the address-to-load gap after last column byte before data.
// [R14] Input mode stores data from the column; supplying data is optional.
// [R15] 85h column change only inside a pending program, before its confirm.
// [R16] 85h with column and row bytes retargets pending program destination.
// [R17] Host waits the address-to-load gap after fifth address byte.
// [R18] Inside pending program, host repeats the original die and plane bits.
// [R19] Device takes five-cycle 85h when fully ready or during cache program.
// [R20] Internal move: 00h-35h loads cache, then 85h overwrites addressed bytes.
// [R21] Column operations can reach any byte of the cache register.
// [R22] Status bit 6 is cache ready, pin follows it; bit 5 array ready.
// [R23] 78h with three row bytes selects one die, deselects the rest.
// [R24] Column bytes go low byte first, high bits second.
module nand_column_host #(
	parameter int COL_BITS = 12,
	parameter int ROW_BITS = 24
) (
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire nand_col_pkg::apb_req_t  apbReq,
	output nand_col_pkg::apb_rsp_t       apbRsp,
	input  wire logic [7:0]              dqIn,
	input  wire logic                    readyBusyPin,
	output nand_col_pkg::nand_pins_t     pins
);
	typedef enum logic [3:0] {
		IDLE, SEND_CMD, SEND_ADDR, SEND_CONFIRM, GAP, DATA_CYC, STROBE_HI, BUS_DONE
	} phase_t;

	typedef struct packed {
		phase_t                   phase;
		logic [2:0]               op;
		logic                     dataWr;
		logic [COL_BITS-1:0]      column;
		logic [ROW_BITS-1:0]      row;
		logic [7:0]               dataOut;
		logic [7:0]               dataIn;
		logic [2:0]               addrIdx;
		logic [2:0]               addrCount;
		logic [7:0]               timer;
		logic [7:0]               gapAfter;
		logic                     strobeLow;
		logic [1:0]               mode;
		logic                     inProgram;
		logic                     badOp;
		logic [1:0]               rdySync;
		nand_col_pkg::nand_pins_t pins;
		nand_col_pkg::apb_rsp_t   rsp;
	} state_t;

	state_t st;
	state_t next_st;

	// Address byte k of the current sequence; column low byte first
	function automatic logic [7:0] addrByte(input logic [COL_BITS-1:0] col,
		input logic [ROW_BITS-1:0] row, input logic [2:0] idx);
		logic [31:0] c;
		logic [31:0] r;
		c = 32'(col);
		r = 32'(row);
		unique case (idx)
			3'h0: addrByte = c[7:0]; // R24 R21
			3'h1: addrByte = c[15:8]; // R24
			3'h2: addrByte = r[7:0];
			3'h3: addrByte = r[15:8];
			default: addrByte = r[23:16];
		endcase
	endfunction

	function automatic logic [7:0] cmdFor(input logic [2:0] op);
		unique case (op)
			nand_col_pkg::OP_RAND_READ:  cmdFor = nand_col_pkg::CMD_RAND_READ; // R1
			nand_col_pkg::OP_RAND_READ2: cmdFor = nand_col_pkg::CMD_RAND_READ_2PL; // R6
			nand_col_pkg::OP_STATUS_ENH: cmdFor = nand_col_pkg::CMD_STATUS_ENH; // R23
			default:                     cmdFor = nand_col_pkg::CMD_RAND_INPUT; // R11 R16
		endcase
	endfunction

	// Ops that end with the read confirm byte
	function automatic logic isReadOp(input logic [2:0] op);
		isReadOp = op == nand_col_pkg::OP_RAND_READ || op == nand_col_pkg::OP_RAND_READ2;
	endfunction

	// Index one past the last address byte; status select starts at the row bytes
	function automatic logic [2:0] addrEnd(input logic [2:0] op);
		unique case (op)
			nand_col_pkg::OP_RAND_READ, nand_col_pkg::OP_RAND_INPUT: addrEnd = 3'h2; // R1 R11
			default:                                                 addrEnd = 3'h5; // R6 R16 R23
		endcase
	endfunction

	// A data byte must run the way the die was last pointed
	function automatic logic dataDirOk(input logic wr, input logic [1:0] mode);
		if (wr)
			dataDirOk = mode == nand_col_pkg::MODE_INPUT; // R14
		else
			dataDirOk = mode == nand_col_pkg::MODE_OUTPUT
				|| mode == nand_col_pkg::MODE_STATUS; // R4
	endfunction

	always_comb
	begin
		logic       wrAcc;
		logic       rdAcc;
		logic [2:0] reqOp;
		// One answer per access phase: a pready already up masks the repeat
		wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite && !st.rsp.pready;
		rdAcc = apbReq.psel && apbReq.penable && !apbReq.pwrite && !st.rsp.pready;
		reqOp = apbReq.pwdata[nand_col_pkg::CTRL_OP_LSB +: 3];
		next_st = st;
		next_st.rsp.pready = 1'b0;
		next_st.rsp.pslverr = 1'b0;
		// Ready pin is asynchronous: two flops before anything reads it
		next_st.rdySync = {st.rdySync[0], readyBusyPin};
		// One down-counter serves strobe widths and gaps
		if (st.timer != 8'h00)
			next_st.timer = st.timer - 8'h01;

		if (rdAcc)
		begin
			next_st.rsp.pready = 1'b1;
			unique case (apbReq.paddr)
				nand_col_pkg::REG_COLUMN: next_st.rsp.prdata = 32'(st.column);
				nand_col_pkg::REG_ROW:    next_st.rsp.prdata = 32'(st.row);
				nand_col_pkg::REG_DATA:   next_st.rsp.prdata = {24'h000000, st.dataIn};
				// Status word: synced ready pin, refusal, mode, busy
				nand_col_pkg::REG_STATUS: next_st.rsp.prdata = {27'h0, st.rdySync[1],
					st.badOp, st.mode, st.phase != IDLE}; // R22
				nand_col_pkg::REG_CTRL:   next_st.rsp.prdata = {27'h0, st.dataWr, 1'b0, st.op};
				// Unmapped offsets answer with an error and zero data
				default:
				begin
					next_st.rsp.prdata = 32'h00000000;
					next_st.rsp.pslverr = 1'b1;
				end
			endcase
		end
		if (wrAcc)
		begin
			next_st.rsp.pready = 1'b1;
			next_st.rsp.prdata = 32'h00000000;
			unique case (apbReq.paddr)
				nand_col_pkg::REG_COLUMN: next_st.column = apbReq.pwdata[COL_BITS-1:0];
				nand_col_pkg::REG_ROW:    next_st.row = apbReq.pwdata[ROW_BITS-1:0];
				nand_col_pkg::REG_DATA:   next_st.dataOut = apbReq.pwdata[7:0];
				nand_col_pkg::REG_STATUS: next_st.badOp = 1'b0;
				nand_col_pkg::REG_CTRL:
				begin
					if (apbReq.pwdata[nand_col_pkg::CTRL_START] && st.phase == IDLE)
					begin
						next_st.op = reqOp;
						next_st.dataWr = apbReq.pwdata[nand_col_pkg::CTRL_DATA_WR];
						next_st.addrIdx = 3'h0;
						next_st.timer = 8'(nand_col_pkg::STROBE_CYC);
						next_st.strobeLow = 1'b1;
						if (reqOp == nand_col_pkg::OP_DATA)
						begin
							if (dataDirOk(apbReq.pwdata[nand_col_pkg::CTRL_DATA_WR], st.mode))
								next_st.phase = DATA_CYC; // R14 R4
							else
								next_st.badOp = 1'b1;
						end
						else if ((reqOp == nand_col_pkg::OP_RAND_INPUT
							|| reqOp == nand_col_pkg::OP_PROG_INPUT) && !apbReq.pwdata[5])
							next_st.badOp = 1'b1; // R15
						else if (reqOp > nand_col_pkg::OP_DATA)
							next_st.badOp = 1'b1;
						else
						begin
							next_st.phase = SEND_CMD;
							next_st.addrCount = addrEnd(reqOp); // R23
							next_st.addrIdx = (reqOp == nand_col_pkg::OP_STATUS_ENH)
								? 3'h2 : 3'h0; // R23
						end
					end
				end
				default: next_st.rsp.pslverr = 1'b1;
			endcase
			// Every ctrl write restates the program window; its own start sees the new value
			if (apbReq.paddr == nand_col_pkg::REG_CTRL)
				next_st.inProgram = apbReq.pwdata[5]; // R15 R18 R20
		end

		// One bus cycle: strobe low for its time, then high for its time
		unique case (st.phase)
			IDLE: next_st.pins.dqOe = 1'b1;
			SEND_CMD, SEND_ADDR, SEND_CONFIRM, DATA_CYC:
			begin
				next_st.pins.cle = (st.phase == SEND_CMD || st.phase == SEND_CONFIRM);
				next_st.pins.ale = (st.phase == SEND_ADDR);
				next_st.pins.dqOe = (st.phase == DATA_CYC) ? !st.dataWr : 1'b0;
				next_st.pins.dq = (st.phase == SEND_CMD) ? cmdFor(st.op)
					: (st.phase == SEND_CONFIRM) ? nand_col_pkg::CMD_READ_CONFIRM
					: (st.phase == SEND_ADDR) ? addrByte(st.column, st.row,
						st.addrIdx)
					: st.dataOut;
				if (st.phase == DATA_CYC && !st.dataWr)
					next_st.pins.readStrobeN = 1'b0;
				else
					next_st.pins.writeStrobeN = 1'b0;
				if (st.timer == 8'h00)
				begin
					// Read byte taken on the last low cycle, before the strobe rises
					if (st.phase == DATA_CYC && !st.dataWr)
						next_st.dataIn = dqIn;
					next_st.pins.readStrobeN = 1'b1;
					next_st.pins.writeStrobeN = 1'b1;
					next_st.timer = 8'(nand_col_pkg::STROBE_CYC);
					next_st.phase = STROBE_HI;
					next_st.gapAfter = 8'h00;
					unique case (st.phase)
						SEND_CMD: next_st.phase = STROBE_HI;
						default: next_st.phase = STROBE_HI;
					endcase
					if (st.phase == SEND_CONFIRM)
						next_st.gapAfter = 8'(nand_col_pkg::CMD_TO_READ_CYC); // R3
					else if (st.phase == SEND_ADDR && st.addrIdx + 3'h1 == st.addrCount
						&& st.op != nand_col_pkg::OP_STATUS_ENH && !isReadOp(st.op))
						next_st.gapAfter = 8'(nand_col_pkg::ADDR_TO_LOAD_CYC); // R13 R17
					else if (st.phase == SEND_ADDR && st.addrIdx + 3'h1 == st.addrCount
						&& st.op == nand_col_pkg::OP_STATUS_ENH)
						next_st.gapAfter = 8'(nand_col_pkg::CMD_TO_READ_CYC);
				end
			end
			STROBE_HI:
			begin
				if (st.timer == 8'h00)
				begin
					next_st.timer = 8'(nand_col_pkg::STROBE_CYC);
					next_st.phase = BUS_DONE;
					// Every command byte but the confirm is followed by address bytes
					if (st.pins.cle && st.pins.dq != nand_col_pkg::CMD_READ_CONFIRM)
						next_st.phase = SEND_ADDR;
					else if (st.pins.ale)
					begin
						next_st.addrIdx = st.addrIdx + 3'h1;
						if (st.addrIdx + 3'h1 != st.addrCount)
							next_st.phase = SEND_ADDR;
						else if (isReadOp(st.op))
							next_st.phase = SEND_CONFIRM; // R1 R6
					end
					if (next_st.phase == BUS_DONE)
					begin
						next_st.timer = st.gapAfter;
						next_st.phase = GAP;
					end
				end
			end
			GAP:
			begin
				// Bus idles with dq released while the gap runs out
				next_st.pins.cle = 1'b0;
				next_st.pins.ale = 1'b0;
				next_st.pins.dqOe = 1'b1;
				if (st.timer == 8'h00)
				begin
					next_st.phase = IDLE;
					unique case (st.op)
						nand_col_pkg::OP_RAND_READ, nand_col_pkg::OP_RAND_READ2:
							next_st.mode = nand_col_pkg::MODE_OUTPUT; // R4 R8
						nand_col_pkg::OP_RAND_INPUT, nand_col_pkg::OP_PROG_INPUT:
							next_st.mode = nand_col_pkg::MODE_INPUT; // R14
						nand_col_pkg::OP_STATUS_ENH:
							next_st.mode = nand_col_pkg::MODE_STATUS; // R5 R10
						default: next_st.mode = st.mode;
					endcase
				end
			end
			default: next_st.phase = IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			// Strobes high and dq released so the die sees no cycle in reset
			st <= '0;
			st.phase <= IDLE;
			st.pins.writeStrobeN <= 1'b1;
			st.pins.readStrobeN <= 1'b1;
			st.pins.dqOe <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign apbRsp = st.rsp;
	assign pins = st.pins;
endmodule // nand_column_host

//--- nand_column_host_properties.sv
// Checker: port-level properties of the NAND column host
module nand_column_host_properties #(
	parameter int COL_BITS = 12,
	parameter int ROW_BITS = 24
) (
	input wire logic                     clk,
	input wire logic                     srst,
	input wire nand_col_pkg::apb_req_t   apbReq,
	input wire nand_col_pkg::apb_rsp_t   apbRsp,
	input wire logic [7:0]               dqIn,
	input wire logic                     readyBusyPin,
	input wire nand_col_pkg::nand_pins_t pins
);
	logic [5:0] sinceW;
	logic       lastAle;
	logic       prevWs;
	logic [7:0] lastCmd;
	logic [2:0] aleCount;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Cycles since the write strobe was last low, saturating
	always_ff @(posedge clk)
	begin
		if (srst || !pins.writeStrobeN)
			sinceW <= 6'h00;
		else if (sinceW != 6'h3f)
			sinceW <= sinceW + 6'h01;
		if (srst)
			lastAle <= 1'b0;
		else if (!pins.writeStrobeN)
			lastAle <= pins.ale;
		// Last command byte and address bytes sent after it
		prevWs <= srst || pins.writeStrobeN;
		if (srst)
		begin
			lastCmd <= 8'h00;
			aleCount <= 3'h0;
		end
		else if (prevWs && !pins.writeStrobeN && pins.cle)
		begin
			lastCmd <= pins.dq;
			aleCount <= 3'h0;
		end
		else if (prevWs && !pins.writeStrobeN && pins.ale)
			aleCount <= aleCount + 3'h1;
	end
	a_strobe_excl: assert property (!(!pins.writeStrobeN && !pins.readStrobeN))
		else $error("read and write strobes low together");
	a_write_drives: assert property (!pins.writeStrobeN |-> !pins.dqOe && !(pins.cle && pins.ale))
		else $error("write cycle without host driving dq");
	a_read_releases: assert property (!pins.readStrobeN |-> pins.dqOe)
		else $error("host drives dq during read strobe");
	a_strobe_width: assert property ($fell(pins.writeStrobeN)
		|-> (!pins.writeStrobeN)[*5] ##1 pins.writeStrobeN)
		else $error("write strobe width wrong");
	a_write_stable: assert property (!pins.writeStrobeN && !$fell(pins.writeStrobeN)
		|-> $stable(pins.dq) && $stable(pins.cle) && $stable(pins.ale))
		else $error("bus cycle changed while strobe low");
	a_read_gap: assert property ($fell(pins.readStrobeN)
		|-> sinceW >= nand_col_pkg::CMD_TO_READ_CYC)
		else $error("read strobe too soon after write cycle");
	a_load_gap: assert property ($fell(pins.writeStrobeN) && !pins.cle && !pins.ale && lastAle
		|-> sinceW >= nand_col_pkg::ADDR_TO_LOAD_CYC)
		else $error("data cycle too soon after address");
	a_apb_answer: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready
		|=> apbRsp.pready)
		else $error("apb answer late");
	a_ready_pulse: assert property (!apbReq.psel || apbRsp.pready |=> !apbRsp.pready)
		else $error("pready not a single pulse");
	a_err_zero: assert property (apbRsp.pslverr && !apbReq.pwrite
		|-> apbRsp.pready && apbRsp.prdata == 32'h0)
		else $error("refused read returned data");
	a_status_rows: assert property ($fell(pins.readStrobeN)
		&& lastCmd == nand_col_pkg::CMD_STATUS_ENH |-> aleCount == 3'h3)
		else $error("status select sent wrong number of row bytes");
endmodule // nand_column_host_properties

bind nand_column_host nand_column_host_properties #(.COL_BITS(COL_BITS), .ROW_BITS(ROW_BITS)) chk (
	.clk(clk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp), .dqIn(dqIn),
	.readyBusyPin(readyBusyPin), .pins(pins));

//--- nand_die_model.sv
// Behavioural NAND die answering the column host on its pins
module nand_die_model #(
	parameter int PLANE_BIT = 6
) (
	input  wire logic                     clk,
	input  wire nand_col_pkg::nand_pins_t pins,
	input  wire logic                     dieBusy,
	output logic [7:0]                    dqIn,
	output logic                          readyBusyPin
);
	logic [7:0]  mem [2][4096];
	logic [7:0]  cmd;
	logic [2:0]  n;
	logic [11:0] col;
	logic        plane = 1'b0;
	logic [1:0]  mode = 2'h0;
	logic        prevW = 1'b1;
	logic        prevR = 1'b1;
	logic [7:0]  last = 8'h00;
	assign readyBusyPin = !dieBusy;
	always @(posedge clk)
	begin
		prevW <= pins.writeStrobeN;
		prevR <= pins.readStrobeN;
		if (!prevW && pins.writeStrobeN)
		begin
			// dieBusy is not checked here, so every sequence is taken
			if (pins.cle)
			begin
				cmd <= pins.dq;
				n <= 3'h0;
				mode <= pins.dq == 8'he0 ? 2'h1 : pins.dq == 8'h85 ? 2'h2 : pins.dq == 8'h78 ? 2'h3 : 2'h0;
			end
			else if (pins.ale)
			begin
				n <= n + 3'h1;
				if (n == 3'h0)
					col[7:0] <= pins.dq;
				if (n == 3'h1)
					col[11:8] <= pins.dq[3:0];
				if (n == 3'h2 && cmd != 8'h78)
					plane <= pins.dq[PLANE_BIT];
			end
			else if (mode == 2'h2)
			begin
				mem[plane][col] <= pins.dq;
				col <= col + 12'h001;
			end
		end
		if (!prevR && pins.readStrobeN && mode == 2'h1)
			col <= col + 12'h001;
		if (!pins.readStrobeN)
			last <= dqIn;
	end
	// Released bus shows the inverse of the last byte, never a held value
	always_comb
		if (pins.readStrobeN)
			dqIn = ~last;
		else if (mode == 2'h3)
			dqIn = {1'b1, !dieBusy, !dieBusy, 5'h00};
		else
			dqIn = mem[plane][col];
endmodule // nand_die_model

//--- nand_column_host_bench.sv
// Bench for the NAND column host: APB master, die model, queued read checks
module nand_column_host_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     clk;
	logic                     srst;
	logic                     dieBusy;
	nand_col_pkg::apb_req_t   req;
	nand_col_pkg::apb_rsp_t   rsp;
	nand_col_pkg::nand_pins_t pins;
	logic [7:0]               dqIn;
	logic                     readyBusyPin;
	logic [32:0]              notes [$];
	logic [32:0]              nt;
	logic [31:0]              r;
	logic [11:0]              cols [2];
	logic [7:0]               dat [2][2];
	int                       nErrors;
	int                       testsRun;
	nand_column_host DUT (.clk(clk), .srst(srst), .apbReq(req), .apbRsp(rsp),
		.dqIn(dqIn), .readyBusyPin(readyBusyPin), .pins(pins));
	nand_die_model partner (.clk(clk), .pins(pins), .dieBusy(dieBusy),
		.dqIn(dqIn), .readyBusyPin(readyBusyPin));
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		testsRun++;
		if (s !== e)
		begin
			nErrors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic summarize();
		if (nErrors == 0 && testsRun > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic c, input logic [31:0] e);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		if (!w)
			notes.push_back({c, e});
		@(posedge clk);
		req.penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge clk);
		while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 32'h0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 1'b1, e);
	endtask
	// Start an operation, then poll until busy drops
	task automatic go(input logic [2:0] op, input logic [31:0] fl);
		wr(nand_col_pkg::REG_CTRL, {29'h0, op} | fl | 32'h8);
		do
			apb(1'b0, nand_col_pkg::REG_STATUS, 32'h0, 1'b0, 32'h0);
		while (r[0] !== 1'b0);
	endtask
	task automatic rb(input logic [31:0] fl, input logic [7:0] e);
		go(nand_col_pkg::OP_DATA, fl);
		rd(nand_col_pkg::REG_DATA, {24'h0, e});
	endtask
	always @(posedge clk)
		if (rsp.pready === 1'b1 && req.pwrite === 1'b0)
		begin
			nt = notes.pop_front();
			if (nt[32])
				check(rsp.prdata, nt[31:0]);
		end
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		#200000;
		nErrors++;
		summarize();
	end
	initial
	begin
		srst = 1'b1;
		dieBusy = 1'b0;
		req = '0;
		nErrors = 0;
		testsRun = 0;
		void'($urandom(24322));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rd(nand_col_pkg::REG_STATUS, 32'h10);
		rd(12'h0ff, 32'h0);
		go(nand_col_pkg::OP_RAND_INPUT, 32'h0);
		rd(nand_col_pkg::REG_STATUS, 32'h18);
		wr(nand_col_pkg::REG_STATUS, 32'h0);
		// Plane 1 uses the top column so the second byte is the last one
		for (int p = 0; p < 2; p++)
		begin
			cols[p] = p ? 12'hffe : 12'($urandom) & 12'hffe;
			wr(nand_col_pkg::REG_COLUMN, {20'h0, cols[p]});
			wr(nand_col_pkg::REG_ROW, {25'h0, p[0], 6'h0});
			go(nand_col_pkg::OP_PROG_INPUT, 32'h20);
			rd(nand_col_pkg::REG_STATUS, 32'h14);
			for (int j = 0; j < 2; j++)
			begin
				dat[p][j] = 8'($urandom);
				wr(nand_col_pkg::REG_DATA, {24'h0, dat[p][j]});
				go(nand_col_pkg::OP_DATA, 32'h30);
			end
			go(nand_col_pkg::OP_RAND_READ2, 32'h20);
			rd(nand_col_pkg::REG_STATUS, 32'h12);
			rb(32'h20, dat[p][0]);
			wr(nand_col_pkg::REG_COLUMN, {20'h0, cols[p] + 12'h001});
			go(nand_col_pkg::OP_RAND_READ, 32'h20);
			rb(32'h20, dat[p][1]);
		end
		wr(nand_col_pkg::REG_COLUMN, {20'h0, cols[0]});
		wr(nand_col_pkg::REG_ROW, 32'h0);
		go(nand_col_pkg::OP_RAND_READ2, 32'h20);
		rb(32'h20, dat[0][0]);
		wr(nand_col_pkg::REG_COLUMN, {20'h0, cols[0] + 12'h001});
		go(nand_col_pkg::OP_RAND_INPUT, 32'h20);
		rd(nand_col_pkg::REG_STATUS, 32'h14);
		wr(nand_col_pkg::REG_DATA, 32'h5a);
		go(nand_col_pkg::OP_DATA, 32'h30);
		wr(nand_col_pkg::REG_COLUMN, {20'h0, cols[0]});
		go(nand_col_pkg::OP_RAND_READ, 32'h20);
		rb(32'h20, dat[0][0]);
		rb(32'h20, 8'h5a);
		go(nand_col_pkg::OP_DATA, 32'h30);
		rd(nand_col_pkg::REG_STATUS, 32'h1a);
		wr(nand_col_pkg::REG_STATUS, 32'h0);
		go(nand_col_pkg::OP_STATUS_ENH, 32'h0);
		rd(nand_col_pkg::REG_STATUS, 32'h16);
		rb(32'h0, 8'he0);
		dieBusy <= 1'b1;
		repeat (6) @(posedge clk);
		rd(nand_col_pkg::REG_STATUS, 32'h06);
		dieBusy <= 1'b0;
		summarize();
	end
endmodule // nand_column_host_bench
